// [ltfc_top.v]
// lin transceiver fault, time-out, watchdog and regulator control logic
`timescale 1ns/100ps
`include "ltfc_defines.vh"
module ltfc_top #(
  parameter [31:0] DOM_CYC   = `LTFC_DOM_CYC,
  parameter [31:0] RETRY_CYC = `LTFC_RETRY_CYC,
  parameter [31:0] WIN_CYC   = `LTFC_WIN_CYC,
  parameter [31:0] DEB_CYC   = `LTFC_DEB_CYC,
  parameter [31:0] WDRST_CYC = `LTFC_WDRST_CYC
) (
  input  wire ref_clk,
  input  wire arst_n,
  input  wire tx_data_in,
  input  wire select_local_wake_in,
  input  wire fault_flag_tx_enable_in,
  input  wire bus_line_pin_in,
  input  wire watchdog_kick_in,
  input  wire watchdog_window_set,
  input  wire supply_valid_in,
  input  wire thermal_hot_in,
  input  wire regulated_supply_short_in,
  input  wire battery_supply_off_in,
  input  wire battery_supply_on_in,
  input  wire wake_from_bus_in,
  output reg  rx_data_out,
  output reg  fault_flag_tx_enable_out,
  output reg  fault_flag_tx_enable_oe_n,
  output reg  bus_line_pin_out,
  output reg  bus_line_pin_oe_n,
  output reg  bus_pullup_en,
  output reg  supply_valid_out,
  output reg  watchdog_reset_out,
  output reg  regulated_supply_en,
  output reg  battery_monitor_en,
  output reg  normal_mode,
  output reg  tx_off_mode
);
  // two-stage synchronisers for every pin input; reset to the idle pin
  // levels so that no false edge or false dominant follows reset
  localparam NS = 12;
  localparam [NS-1:0] SYNC_IDLE = `LTFC_SYNC_IDLE;
  wire [NS-1:0] raw_in = {tx_data_in, select_local_wake_in,
    fault_flag_tx_enable_in, bus_line_pin_in, watchdog_kick_in,
    watchdog_window_set, supply_valid_in, thermal_hot_in,
    regulated_supply_short_in, battery_supply_off_in,
    battery_supply_on_in, wake_from_bus_in};
  reg  [NS-1:0] s1_reg;
  reg  [NS-1:0] s2_reg;
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_reg[gi] <= SYNC_IDLE[gi];
          s2_reg[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_reg[gi] <= raw_in[gi];
          s2_reg[gi] <= s1_reg[gi];
        end
      end
    end
  endgenerate
  wire txd   = s2_reg[11];
  wire sel   = s2_reg[10];
  wire fen   = s2_reg[9];
  wire bus   = s2_reg[8];
  wire kick  = s2_reg[7];
  wire wd_en = s2_reg[6];
  wire sup   = s2_reg[5];
  wire hot   = s2_reg[4];
  wire shrt  = s2_reg[3];
  wire boff  = s2_reg[2];
  wire bon   = s2_reg[1];
  wire wbus  = s2_reg[0];

  reg  [31:0] dom_reg;
  reg  [31:0] deb_reg;
  reg  [31:0] wd_reg;
  reg  [31:0] rg_reg;
  reg  [1:0]  wd_st_reg;
  reg  [1:0]  rg_st_reg;
  reg         kick_d_reg;
  reg         wake_bus_reg;

  // dominant time-out: cleared by any recessive level or reset
  wire dom_to = (dom_reg >= DOM_CYC);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      dom_reg <= 32'h0000_0000;
    else if (bus)
      dom_reg <= 32'h0000_0000;
    else if (!dom_to)
      dom_reg <= dom_reg + 32'h0000_0001;
  end

  // mismatch debounce restarts at every tx edge so propagation delay
  // of the bus never shows as a false fault
  reg txd_d_reg;
  wire deb_ok = (deb_reg >= DEB_CYC);
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      deb_reg   <= 32'h0000_0000;
      txd_d_reg <= 1'b1;
    end else begin
      txd_d_reg <= txd;
      if (txd != txd_d_reg)
        deb_reg <= 32'h0000_0000;
      else if (!deb_ok)
        deb_reg <= deb_reg + 32'h0000_0001;
    end
  end

  // wake source latched while select low; bus wake wins over power-on
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      wake_bus_reg <= 1'b0;
    else if (sel)
      wake_bus_reg <= 1'b0;
    else if (wbus)
      wake_bus_reg <= 1'b1;
  end

  // fault flag: own pull-low sources; host low only changes mode
  wire mism   = !txd && bus && deb_ok && !hot;
  wire own_lo = sel ? (mism || hot || dom_to)
                    : wake_bus_reg;
  // tx is off when the pin is low, whoever pulls it
  wire pin_lo = own_lo || !fen;
  wire tx_on  = sel && !pin_lo && !hot && !dom_to;

  // watchdog: open window from half length to full length
  wire wd_half = (wd_reg >= (WIN_CYC >> 1));
  wire wd_full = (wd_reg >= WIN_CYC);
  wire kick_fall = kick_d_reg && !kick;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_st_reg  <= `LTFC_WD_OFF;
      wd_reg     <= 32'h0000_0000;
      kick_d_reg <= 1'b1;
    end else begin
      kick_d_reg <= kick;
      case (wd_st_reg)
        `LTFC_WD_OFF: begin
          wd_reg <= 32'h0000_0000;
          if (wd_en)
            wd_st_reg <= `LTFC_WD_RUN;
        end
        `LTFC_WD_RUN: begin
          if (!wd_en)
            wd_st_reg <= `LTFC_WD_OFF;
          else if ((kick_fall && !wd_half) || wd_full) begin
            wd_st_reg <= `LTFC_WD_RST;
            wd_reg    <= 32'h0000_0000;
          end else if (kick_fall)
            wd_reg <= 32'h0000_0000;
          else
            wd_reg <= wd_reg + 32'h0000_0001;
        end
        `LTFC_WD_RST: begin
          if (wd_reg >= WDRST_CYC - 32'h0000_0001) begin
            wd_st_reg <= `LTFC_WD_RUN;
            wd_reg    <= 32'h0000_0000;
          end else
            wd_reg <= wd_reg + 32'h0000_0001;
        end
        default: wd_st_reg <= `LTFC_WD_OFF;
      endcase
    end
  end

  // regulator sequencing: short retry and battery collapse recovery
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rg_st_reg <= `LTFC_RG_ON;
      rg_reg    <= 32'h0000_0000;
    end else begin
      case (rg_st_reg)
        `LTFC_RG_ON: begin
          rg_reg <= 32'h0000_0000;
          if (boff)
            rg_st_reg <= `LTFC_RG_BAT;
          else if (shrt)
            rg_st_reg <= `LTFC_RG_WAIT;
        end
        `LTFC_RG_WAIT: begin
          if (rg_reg >= RETRY_CYC - 32'h0000_0001) begin
            rg_reg <= 32'h0000_0000;
            rg_st_reg <= `LTFC_RG_ON;
          end else
            rg_reg <= rg_reg + 32'h0000_0001;
        end
        `LTFC_RG_BAT: begin
          if (bon)
            rg_st_reg <= `LTFC_RG_ON;
        end
        default: rg_st_reg <= `LTFC_RG_ON;
      endcase
    end
  end

  // registered outputs; open-drain enables active low
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_out               <= 1'b1;
      fault_flag_tx_enable_out  <= 1'b0;
      fault_flag_tx_enable_oe_n <= 1'b1;
      bus_line_pin_out          <= 1'b0;
      bus_line_pin_oe_n         <= 1'b1;
      bus_pullup_en             <= 1'b1;
      supply_valid_out          <= 1'b0;
      watchdog_reset_out        <= 1'b1;
      regulated_supply_en       <= 1'b1;
      battery_monitor_en        <= 1'b0;
      normal_mode               <= 1'b0;
      tx_off_mode               <= 1'b0;
    end else begin
      rx_data_out               <= bus || dom_to;
      fault_flag_tx_enable_oe_n <= !own_lo;
      bus_line_pin_oe_n         <= !(tx_on && !txd);
      bus_pullup_en             <= !dom_to;
      supply_valid_out          <= sup;
      watchdog_reset_out        <= (wd_st_reg != `LTFC_WD_RST);
      regulated_supply_en       <= !hot &&
                                   (rg_st_reg == `LTFC_RG_ON);
      battery_monitor_en        <= sel || wake_bus_reg;
      normal_mode               <= tx_on;
      tx_off_mode               <= sel && !tx_on;
    end
  end
endmodule

// [ltfc_defines.vh]
// constants for the lin transceiver fault and supervision control block
`ifndef LTFC_DEFINES_VH
`define LTFC_DEFINES_VH
`define LTFC_CLK_MHZ        100
`define LTFC_DEB_TIME_US    25
`define LTFC_DEB_CYC        (`LTFC_DEB_TIME_US * `LTFC_CLK_MHZ)
`define LTFC_DOM_TIME_MS    20
`define LTFC_DOM_CYC        (`LTFC_DOM_TIME_MS * 1000 * `LTFC_CLK_MHZ)
`define LTFC_RETRY_TIME_MS  3
`define LTFC_RETRY_CYC      (`LTFC_RETRY_TIME_MS * 1000 * `LTFC_CLK_MHZ)
`define LTFC_WDRST_TIME_US  150
`define LTFC_WDRST_CYC      (`LTFC_WDRST_TIME_US * `LTFC_CLK_MHZ)
`define LTFC_WIN_TIME_MS    7
`define LTFC_WIN_CYC        (`LTFC_WIN_TIME_MS * 1000 * `LTFC_CLK_MHZ)
`define LTFC_CNT_W          32
// synchroniser reset levels: tx, flag, bus and kick pins idle high
`define LTFC_SYNC_IDLE      12'hb80
`define LTFC_WD_RUN         2'h0
`define LTFC_WD_RST         2'h1
`define LTFC_WD_OFF         2'h2
`define LTFC_RG_ON          2'h0
`define LTFC_RG_WAIT        2'h1
`define LTFC_RG_BAT         2'h2
`endif

// [ltfc_top_properties.sv]
// port-level assertions for the lin transceiver control block
`timescale 1ns/100ps
module ltfc_properties #(
  parameter [31:0] DOM_CYC   = 32'h0000_00c8,
  parameter [31:0] WDRST_CYC = 32'h0000_0008
) (
  input wire ref_clk,
  input wire arst_n,
  input wire tx_data_in,
  input wire select_local_wake_in,
  input wire fault_flag_tx_enable_in,
  input wire bus_line_pin_in,
  input wire supply_valid_in,
  input wire thermal_hot_in,
  input wire rx_data_out,
  input wire fault_flag_tx_enable_oe_n,
  input wire bus_line_pin_oe_n,
  input wire bus_pullup_en,
  input wire supply_valid_out,
  input wire watchdog_reset_out,
  input wire regulated_supply_en,
  input wire normal_mode,
  input wire tx_off_mode
);
  logic [31:0] dom_cnt;
  logic [31:0] low_cnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // run lengths of a low bus and a low watchdog output
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dom_cnt <= 32'h0;
      low_cnt <= 32'h0;
    end else begin
      dom_cnt <= bus_line_pin_in ? 32'h0 : dom_cnt + 32'h1;
      low_cnt <= watchdog_reset_out ? 32'h0 : low_cnt + 32'h1;
    end
  end
  // pulse comes from unsynchronised state, so its length is exact
  sequence s_pulse_done;
    $rose(watchdog_reset_out) ##0 (low_cnt == WDRST_CYC);
  endsequence
  a_supply_valid_follow: assert property ($stable(supply_valid_in)[*5] |->
    supply_valid_out == supply_valid_in) else $error("supply valid wrong");
  a_rx_follows_bus: assert property (($stable(bus_line_pin_in) &&
    bus_pullup_en)[*5] |-> rx_data_out == bus_line_pin_in)
    else $error("rx not following bus");
  a_txoff_no_drive: assert property (tx_off_mode[*3] |-> bus_line_pin_oe_n)
    else $error("bus driven in tx-off");
  a_mode_by_pins: assert property ($stable({select_local_wake_in,
    fault_flag_tx_enable_in})[*5] |-> normal_mode == (select_local_wake_in
    && fault_flag_tx_enable_in)) else $error("mode wrong");
  a_thermal_flag_low: assert property ((select_local_wake_in &&
    thermal_hot_in)[*5] |-> !fault_flag_tx_enable_oe_n)
    else $error("thermal not flagged");
  a_thermal_all_off: assert property (thermal_hot_in[*5] |->
    !regulated_supply_en && bus_line_pin_oe_n) else $error("thermal on");
  a_dominant_timeout: assert property (dom_cnt == DOM_CYC + 32'h4 &&
    select_local_wake_in |-> !bus_pullup_en && rx_data_out &&
    bus_line_pin_oe_n && !fault_flag_tx_enable_oe_n)
    else $error("dominant timeout missing");
  a_wd_pulse_len: assert property ($rose(watchdog_reset_out) |->
    s_pulse_done) else $error("watchdog pulse short");
endmodule

// [ltfc_bus_model.sv]
// far side: shared bus wire with another node, host on the flag pin
`timescale 1ns/100ps
module ltfc_bus_model (
  input  wire dut_bus_oe_n,
  input  wire dut_flt_oe_n,
  input  wire dut_bus_out,
  input  wire dut_flt_out,
  input  wire node_dom,
  input  wire bus_short,
  input  wire host_low,
  output wire bus_level,
  output wire flt_level
);
  // wire-and with pull-up; a short to battery overrides every driver
  assign bus_level = bus_short |
                     ((dut_bus_oe_n | dut_bus_out) & ~node_dom);
  // external pull-up unless host or device pulls low
  assign flt_level = (dut_flt_oe_n | dut_flt_out) & ~host_low;
endmodule

// [ltfc_top_bench.sv]
// self-checking bench for the lin transceiver control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0b got %0b", n, e, g); end end
module ltfc_top_bench;
  logic ref_clk = 1'b0, arst_n = 1'b0, tx = 1'b1, sel = 1'b0, hlow = 1'b0;
  logic kick = 1'b1, wsel = 1'b0, sv = 1'b1, hot = 1'b0, shrt = 1'b0;
  logic boff = 1'b0, bon = 1'b1, wake = 1'b0, node = 1'b0, stuck = 1'b0;
  wire  rx, f_oe, b_oe, pu, sv_o, wd_o, reg_en, mon, nrm, toff, bus, fpin;
  wire  fo, bo;
  int   err_count = 0;
  int   n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  ltfc_top #(.DOM_CYC(200), .RETRY_CYC(60), .WIN_CYC(100), .DEB_CYC(10),
    .WDRST_CYC(8)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .tx_data_in(tx), .select_local_wake_in(sel),
    .fault_flag_tx_enable_in(fpin), .bus_line_pin_in(bus),
    .watchdog_kick_in(kick), .watchdog_window_set(wsel),
    .supply_valid_in(sv), .thermal_hot_in(hot),
    .regulated_supply_short_in(shrt), .battery_supply_off_in(boff),
    .battery_supply_on_in(bon), .wake_from_bus_in(wake),
    .rx_data_out(rx), .fault_flag_tx_enable_out(fo),
    .fault_flag_tx_enable_oe_n(f_oe), .bus_line_pin_out(bo),
    .bus_line_pin_oe_n(b_oe), .bus_pullup_en(pu),
    .supply_valid_out(sv_o), .watchdog_reset_out(wd_o),
    .regulated_supply_en(reg_en), .battery_monitor_en(mon),
    .normal_mode(nrm), .tx_off_mode(toff));
  ltfc_bus_model far (.dut_bus_oe_n(b_oe), .dut_flt_oe_n(f_oe),
    .dut_bus_out(bo), .dut_flt_out(fo),
    .node_dom(node), .bus_short(stuck), .host_low(hlow),
    .bus_level(bus), .flt_level(fpin));
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // kick edge needs a high cycle before the next one
  task kick_wd;
    kick = 1'b0;
    step(2);
    kick = 1'b1;
    step(2);
  endtask
  task wait_wd(input logic v, input int n);
    for (int i = 0; i < n && wd_o !== v; i++) step(1);
    `CHK("wd_reset", v, wd_o)
  endtask
  task end_of_test;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    step(12);
    `CHK("rst_rx", 1'b1, rx)
    `CHK("rst_pu", 1'b1, pu)
    arst_n = 1'b1;
    step(6);
    `CHK("sv_hi", 1'b1, sv_o)
    sv = 1'b0;
    step(5);
    `CHK("sv_lo", 1'b0, sv_o)
    sv = 1'b1;
    sel = 1'b1;
    tx = 1'b0;
    step(16);
    `CHK("normal", 1'b1, nrm)
    `CHK("bus_dom", 1'b0, bus)
    `CHK("rx_dom", 1'b0, rx)
    `CHK("flag_ok", 1'b1, f_oe)
    tx = 1'b1;
    node = 1'b1;
    step(6);
    `CHK("rx_node", 1'b0, rx)
    `CHK("flag_rcv", 1'b1, f_oe)
    node = 1'b0;
    hlow = 1'b1;
    tx = 1'b0;
    step(6);
    `CHK("txoff", 1'b1, toff)
    `CHK("bus_rel", 1'b1, bus)
    hlow = 1'b0;
    tx = 1'b1;
    step(6);
    stuck = 1'b1;
    tx = 1'b0;
    step(5);
    `CHK("flag_deb", 1'b1, f_oe)
    step(12);
    `CHK("flag_short", 1'b0, f_oe)
    `CHK("diag_short", 1'b1, rx)
    tx = 1'b1;
    stuck = 1'b0;
    step(6);
    hot = 1'b1;
    step(6);
    `CHK("flag_hot", 1'b0, f_oe)
    `CHK("reg_hot", 1'b0, reg_en)
    hot = 1'b0;
    step(6);
    `CHK("reg_cool", 1'b1, reg_en)
    node = 1'b1;
    step(208);
    `CHK("pu_off", 1'b0, pu)
    `CHK("rx_forced", 1'b1, rx)
    node = 1'b0;
    step(6);
    `CHK("pu_back", 1'b1, pu)
    shrt = 1'b1;
    step(5);
    `CHK("reg_short", 1'b0, reg_en)
    shrt = 1'b0;
    step(30);
    `CHK("reg_wait", 1'b0, reg_en)
    step(40);
    `CHK("reg_retry", 1'b1, reg_en)
    boff = 1'b1;
    bon = 1'b0;
    step(5);
    `CHK("reg_boff", 1'b0, reg_en)
    boff = 1'b0;
    bon = 1'b1;
    step(6);
    `CHK("reg_bon", 1'b1, reg_en)
    sel = 1'b0;
    step(6);
    `CHK("mon_down", 1'b0, mon)
    `CHK("flag_por", 1'b1, f_oe)
    wake = 1'b1;
    step(4);
    wake = 1'b0;
    step(4);
    `CHK("flag_wake", 1'b0, f_oe)
    sel = 1'b1;
    wsel = 1'b1;
    step(70);
    kick_wd;
    step(10);
    `CHK("wd_kept", 1'b1, wd_o)
    kick_wd;
    wait_wd(1'b0, 6);
    wait_wd(1'b1, 20);
    step(80);
    `CHK("wd_run", 1'b1, wd_o)
    wait_wd(1'b0, 40);
    end_of_test;
  end
  // hang guard, well beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    end_of_test;
  end
endmodule
bind ltfc_top ltfc_properties #(.DOM_CYC(DOM_CYC), .WDRST_CYC(WDRST_CYC)) chk (
  .ref_clk, .arst_n, .tx_data_in, .select_local_wake_in,
  .fault_flag_tx_enable_in, .bus_line_pin_in, .supply_valid_in,
  .thermal_hot_in, .rx_data_out, .fault_flag_tx_enable_oe_n,
  .bus_line_pin_oe_n, .bus_pullup_en, .supply_valid_out,
  .watchdog_reset_out, .regulated_supply_en, .normal_mode, .tx_off_mode);
